// ==== shared/ltcb_pkg.sv ====
package ltcb_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h0c;
  localparam logic [7:0] RAM_IDX_OFF = 8'h10;
  localparam logic [7:0] RAM_DATA0_OFF = 8'h20;
  // control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SUSP_EN_BIT = 1;
  // interrupt bit positions
  localparam int IRQ_HALF0_BIT = 0;
  localparam int IRQ_HALF1_BIT = 1;
  localparam int IRQ_STALL_BIT = 2;
  // trace word field positions
  localparam int TW_K287_BIT = 15;
  localparam int TW_FSYNC_BIT = 14;
  localparam int TW_BERR_BIT = 13;
  localparam int TW_KCHAR_BIT = 12;
  localparam int TW_EVT_LSB = 8;
  // geometry
  localparam int RAM_DEPTH = 64;
  localparam int WORDS_PER_ENTRY = 8;
  localparam int LINK_COUNT = 6;
  localparam logic [7:0] K287_CODE = 8'hfc;
  localparam logic [5:0] HALF0_LAST = 6'h1f;
  localparam logic [5:0] HALF1_LAST = 6'h3f;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [2:0] MASK_RST = 3'h0;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {WR_IDLE, WR_WAIT, WR_RESP} ltcb_wr_t;
endpackage

// ==== logic/ltcb_top.sv ====
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module ltcb_top
  import ltcb_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // receive link mac byte stream (already link-selected)
  input wire logic [2:0] LINK_SEL,
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  input wire logic BYTE_KCHAR,
  input wire logic BYTE_ERR,
  // side strobes
  input wire logic [3:0] SYS_EVT,
  input wire logic FRAME_STROBE,
  input wire logic EMU_SUSPEND,
  // dma trigger and interrupt
  output logic DMA_EVENT,
  output logic IRQ,
  // axi4-lite write address
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // axi4-lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read address
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // axi4-lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import ltcb_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [31:0] ctrl_r; // control word
  logic [2:0] irq_stat_r; // sticky events
  logic [2:0] irq_mask_r; // event mask
  logic [5:0] ram_idx_r; // bus window entry index
  logic [127:0] ram_r [RAM_DEPTH]; // capture memory
  logic [127:0] stage_r; // staging quadword
  logic [2:0] stage_cnt_r; // words staged
  logic [5:0] wr_addr_r; // capture write pointer
  logic [3:0] evt_d_r; // previous event levels
  logic [3:0] evt_pend_r; // edges awaiting a byte
  logic fs_d_r; // previous frame strobe
  logic fs_pend_r; // frame edge awaiting byte
  logic ram_we; // capture write this cycle
  logic cap_on; // capture active
  logic [15:0] tword; // assembled trace word
  logic [3:0] evt_rise; // event rising edges
  logic fs_rise; // frame strobe rising edge
  logic half_done; // filled half event
  ltcb_wr_t wst_r; // write channel state
  logic [7:0] awaddr_r; // latched write address
  logic [31:0] wdata_r; // latched write data
  logic [3:0] wstrb_r; // latched strobes
  logic aw_got_r; // address held
  logic w_got_r; // data held
  logic wr_ram_hit; // write aims at ram window
  logic wr_stall_r; // bus write stalled once
  logic [31:0] rd_word; // read mux result
  logic rd_err; // unmapped read
  logic [2:0] irq_set; // status bits raised this cycle
  logic [2:0] irq_clr; // status bits cleared by software

  // ------------------------------------------------------------
  // capture path
  // ------------------------------------------------------------
  // enable gated by suspend when suspend honouring is set
  assign cap_on = ctrl_r[CTRL_EN_BIT] & ~(EMU_SUSPEND & ctrl_r[CTRL_SUSP_EN_BIT]);
  assign evt_rise = SYS_EVT & ~evt_d_r;
  assign fs_rise = FRAME_STROBE & ~fs_d_r;

  // trace word build
  always_comb begin
    tword = 16'h0000;
    tword[7:0] = BYTE_DATA;
    tword[TW_KCHAR_BIT] = BYTE_KCHAR;
    tword[TW_K287_BIT] = BYTE_KCHAR & (BYTE_DATA == K287_CODE);
    tword[TW_BERR_BIT] = BYTE_ERR;
    tword[TW_EVT_LSB +: 4] = evt_pend_r | evt_rise;
    tword[TW_FSYNC_BIT] = fs_pend_r | fs_rise;
  end

  // edge registers, cleared once tied to a byte
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_d_r <= 4'h0;
      fs_d_r <= 1'b0;
      evt_pend_r <= 4'h0;
      fs_pend_r <= 1'b0;
    end else begin
      evt_d_r <= SYS_EVT;
      fs_d_r <= FRAME_STROBE;
      if (BYTE_VALID) begin
        evt_pend_r <= 4'h0;
        fs_pend_r <= 1'b0;
      end else begin
        evt_pend_r <= evt_pend_r | evt_rise;
        fs_pend_r <= fs_pend_r | fs_rise;
      end
    end
  end

  // staging register, one quadword
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stage_r <= 128'h0;
      stage_cnt_r <= 3'h0;
    end else if (!ctrl_r[CTRL_EN_BIT]) begin
      stage_cnt_r <= 3'h0;
    end else if (cap_on && BYTE_VALID) begin
      stage_r[stage_cnt_r*16 +: 16] <= tword;
      stage_cnt_r <= stage_cnt_r + 3'h1;
    end
  end

  // full quadword goes to ram on the eighth word
  assign ram_we = cap_on && BYTE_VALID && (stage_cnt_r == 3'(WORDS_PER_ENTRY - 1));
  assign half_done = ram_we && (wr_addr_r == HALF0_LAST || wr_addr_r == HALF1_LAST);

  // circular write pointer
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_addr_r <= 6'h00;
    end else if (ram_we) begin
      wr_addr_r <= wr_addr_r + 6'h01;
    end
  end

  // capture memory, capture port wins over the bus
  always_ff @(posedge MCLK) begin
    if (ram_we) begin
      ram_r[wr_addr_r] <= {tword, stage_r[111:0]};
    end else if (wst_r == WR_WAIT && wr_ram_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_r[b]) begin
          ram_r[ram_idx_r][(awaddr_r[3:2]*32) + b*8 +: 8] <= wdata_r[b*8 +: 8];
        end
      end
    end
  end

  // dma trigger pulse per filled half, rate set by byte rate
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DMA_EVENT <= 1'b0;
    end else begin
      DMA_EVENT <= half_done;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  // event vector and write-one-to-clear vector
  always_comb begin
    irq_set = {wst_r == WR_WAIT && wr_ram_hit && ram_we, // stalled bus write
               half_done && wr_addr_r == HALF1_LAST,
               half_done && wr_addr_r == HALF0_LAST};
    irq_clr = 3'h0;
    if (wst_r == WR_WAIT && awaddr_r == IRQ_STAT_OFF && wstrb_r[0]) begin
      irq_clr = wdata_r[2:0];
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat_r <= 3'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write side
  // ------------------------------------------------------------
  assign wr_ram_hit = (awaddr_r[7:4] == RAM_DATA0_OFF[7:4]);

  // address and data taken in either order
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wst_r <= WR_IDLE;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      wr_stall_r <= 1'b0;
    end else begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      case (wst_r)
        WR_IDLE: begin
          if (AWVALID && !aw_got_r && !AWREADY) begin
            AWREADY <= 1'b1;
          end
          if (WVALID && !w_got_r && !WREADY) begin
            WREADY <= 1'b1;
          end
          if (AWVALID && AWREADY) begin
            aw_got_r <= 1'b1;
            awaddr_r <= AWADDR;
          end
          if (WVALID && WREADY) begin
            w_got_r <= 1'b1;
            wdata_r <= WDATA;
            wstrb_r <= WSTRB;
          end
          if ((aw_got_r || (AWVALID && AWREADY)) && (w_got_r || (WVALID && WREADY))) begin
            wst_r <= WR_WAIT;
          end
        end
        WR_WAIT: begin
          // ram write stalls while capture owns the port
          if (wr_ram_hit && ram_we) begin
            wr_stall_r <= 1'b1;
          end else begin
            wr_stall_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= (wr_ram_hit || awaddr_r <= RAM_IDX_OFF) ? RESP_OKAY : RESP_SLVERR;
            wst_r <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (BREADY) begin
            BVALID <= 1'b0;
            wst_r <= WR_IDLE;
          end
        end
        default: wst_r <= WR_IDLE;
      endcase
    end
  end

  // register writes
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_r <= CTRL_RST;
      irq_mask_r <= MASK_RST;
      ram_idx_r <= 6'h00;
    end else if (wst_r == WR_WAIT && wstrb_r[0]) begin
      case (awaddr_r)
        CTRL_OFF: ctrl_r <= {30'h0, wdata_r[1:0]};
        IRQ_MASK_OFF: irq_mask_r <= wdata_r[2:0];
        RAM_IDX_OFF: ram_idx_r <= wdata_r[5:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read side
  // ------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0;
    rd_err = 1'b0;
    if (ARADDR[7:4] == RAM_DATA0_OFF[7:4]) begin
      rd_word = ram_r[ram_idx_r][ARADDR[3:2]*32 +: 32]; // readable in suspend
    end else begin
      case (ARADDR)
        CTRL_OFF: rd_word = ctrl_r;
        STAT_OFF: rd_word = {20'h0, LINK_SEL, stage_cnt_r, wr_addr_r};
        IRQ_STAT_OFF: rd_word = {29'h0, irq_stat_r};
        IRQ_MASK_OFF: rd_word = {29'h0, irq_mask_r};
        RAM_IDX_OFF: rd_word = {26'h0, ram_idx_r};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // one read at a time, answer one cycle after acceptance
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= RESP_OKAY;
    end else begin
      ARREADY <= 1'b0;
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
      if (ARVALID && !ARREADY && !RVALID) begin
        ARREADY <= 1'b1;
      end
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA <= rd_word;
        RRESP <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

endmodule // ltcb_top

// ==== bench/ltcb_props.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// port checker for the capture block
// ----------------------------------------
module ltcb_props (
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // capture side
  input wire logic BYTE_VALID,
  input wire logic DMA_EVENT,
  input wire logic IRQ,
  // bus side
  input wire logic AWREADY,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY
);
  import ltcb_pkg::*;
  logic [9:0] bytes_r; // bytes since last dma event
  logic [2:0] idle_r; // cycles since last byte
  // counters, saturating so they never wrap
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bytes_r <= 10'h0;
      idle_r <= 3'h0;
    end else begin
      if (DMA_EVENT) bytes_r <= {9'h0, BYTE_VALID};
      else if (BYTE_VALID && !(&bytes_r)) bytes_r <= bytes_r + 10'h1;
      if (BYTE_VALID) idle_r <= 3'h0;
      else if (!(&idle_r)) idle_r <= idle_r + 3'h1;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  a_dma_one_cycle: assert property (DMA_EVENT |=> !DMA_EVENT) else $error("dma pulse long");
  a_dma_half_full: assert property (DMA_EVENT |-> bytes_r >= 10'd253)
    else $error("dma event before half filled");
  a_dma_near_byte: assert property (DMA_EVENT |-> idle_r <= 3'h5)
    else $error("dma event without capture");
  a_rd_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_wr_resp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_rd_answer: assert property (ARVALID && ARREADY |=> RVALID) else $error("read late");
  a_ar_pulse: assert property (ARREADY |=> !ARREADY) else $error("arready held");
  a_aw_w_pulse: assert property (AWREADY || WREADY |=> !AWREADY && !WREADY)
    else $error("write ready held");
  a_resp_legal: assert property (RVALID |-> RRESP == RESP_OKAY || RRESP == RESP_SLVERR)
    else $error("bad read response");
  c_dma: cover property (DMA_EVENT);
  c_irq: cover property ($rose(IRQ));
  c_slverr: cover property (BVALID && BRESP == RESP_SLVERR);
endmodule // ltcb_props
bind ltcb_top ltcb_props u_props (.MCLK, .ARST_N, .BYTE_VALID, .DMA_EVENT, .IRQ, .AWREADY,
  .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);

// ==== bench/ltcb_dma_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// dma engine model: counts events and tracks the half each one claims
// ----------------------------------------
module ltcb_dma_model (
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // trigger
  input wire logic DMA_EVENT,
  // bookkeeping
  output int evt_count,
  output logic [5:0] half_base
);
  // each event claims the half just filled, the other is being written
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_count <= 0;
      half_base <= 6'h20;
    end else if (DMA_EVENT) begin
      evt_count <= evt_count + 1;
      half_base <= half_base ^ 6'h20;
    end
  end
endmodule // ltcb_dma_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// bench top
// ----------------------------------------
module tb_top;
  import ltcb_pkg::*;
  logic MCLK = 0, ARST_N = 0, BYTE_VALID = 0, BYTE_KCHAR = 0, BYTE_ERR = 0;
  logic FRAME_STROBE = 0, EMU_SUSPEND = 0, DMA_EVENT, IRQ;
  logic [2:0] LINK_SEL = 3'h0;
  logic [7:0] BYTE_DATA = 8'h0, AWADDR = 8'h0, ARADDR = 8'h0;
  logic [3:0] SYS_EVT = 4'h0, WSTRB = 4'h0;
  logic AWVALID = 0, AWREADY, WVALID = 0, WREADY, BVALID, BREADY = 0;
  logic ARVALID = 0, ARREADY, RVALID, RREADY = 0;
  logic [31:0] WDATA = 32'h0, RDATA, rd;
  logic [1:0] BRESP, RRESP, rs;
  int err_count = 0, tests_run = 0, cyc = 0, cnt = 0, ev;
  logic [15:0] mem [64][8]; // expected ram words
  logic [5:0] wp = 6'h0, hb; // expected write entry
  logic [3:0] ev_old = 4'h0; // last event levels
  logic fs_old = 0;
  always #2 MCLK = ~MCLK;
  ltcb_top DUT (.MCLK, .ARST_N, .LINK_SEL, .BYTE_VALID, .BYTE_DATA, .BYTE_KCHAR, .BYTE_ERR,
    .SYS_EVT, .FRAME_STROBE, .EMU_SUSPEND, .DMA_EVENT, .IRQ, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
    .RDATA, .RRESP, .RVALID, .RREADY);
  ltcb_dma_model dma (.MCLK, .ARST_N, .DMA_EVENT, .evt_count(ev), .half_base(hb));
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // counts, verdict, stop
  task end_sim();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // axi write: both channels offered, each released when taken
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hf;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw && w)) begin
      @(posedge MCLK);
      if (AWREADY === 1'b1) begin
        aw = 1;
        AWVALID <= 1'b0;
      end
      if (WREADY === 1'b1) begin
        w = 1;
        WVALID <= 1'b0;
      end
    end
    do @(posedge MCLK); while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
    @(posedge MCLK);
  endtask
  // axi read
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge MCLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    while (RVALID !== 1'b1) @(posedge MCLK);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    @(posedge MCLK);
  endtask
  // back-to-back random bytes; model stores them only when capturing
  task bytes(input int n, input bit cap);
    logic [7:0] d;
    logic k, e, f;
    logic [3:0] s;
    repeat (n) begin
      d = ($urandom % 4 == 0) ? K287_CODE : 8'($urandom);
      k = 1'($urandom);
      e = 1'($urandom);
      s = cap ? 4'($urandom) : 4'h0;
      f = cap ? 1'($urandom) : 1'b0;
      BYTE_VALID <= 1'b1;
      BYTE_DATA <= d;
      BYTE_KCHAR <= k;
      BYTE_ERR <= e;
      SYS_EVT <= s;
      FRAME_STROBE <= f;
      if (cap) begin
        mem[wp][cnt] = {k && d == K287_CODE, f & ~fs_old, e, k, s & ~ev_old, d};
        cnt = (cnt + 1) % 8;
        if (cnt == 0) wp = wp + 6'h1;
      end
      ev_old = s;
      fs_old = f;
      @(posedge MCLK);
    end
    BYTE_VALID <= 1'b0;
    repeat (4) @(posedge MCLK);
  endtask
  // hang guard
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'h448a2007));
    LINK_SEL <= 3'($urandom % 6);
    repeat (3) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    axr(CTRL_OFF, rd, rs);
    chk(rd, CTRL_RST, "ctrl reset");
    axr(IRQ_MASK_OFF, rd, rs);
    chk(rd, {29'h0, MASK_RST}, "mask reset");
    axr(8'hfc, rd, rs);
    chk(rs, RESP_SLVERR, "unmapped read");
    axw(8'hf8, 32'h1, rs);
    chk(rs, RESP_SLVERR, "unmapped write");
    bytes(16, 0);
    axr(STAT_OFF, rd, rs);
    chk(rd[5:0], 6'h0, "idle pointer");
    chk(rd[11:9], LINK_SEL, "link select");
    axw(CTRL_OFF, 32'h1, rs);
    bytes(3, 1);
    axw(CTRL_OFF, 32'h0, rs);
    cnt = 0;
    axr(STAT_OFF, rd, rs);
    chk(rd[8:6], 3'h0, "staging dropped");
    axw(CTRL_OFF, 32'h1, rs);
    axw(IRQ_MASK_OFF, 32'h1, rs);
    bytes(256, 1);
    chk(ev, 1, "first dma");
    chk(hb, 6'h0, "first half");
    chk(IRQ, 1'b1, "irq raised");
    axw(IRQ_STAT_OFF, 32'h1, rs);
    repeat (2) @(posedge MCLK);
    chk(IRQ, 1'b0, "irq cleared");
    bytes(256, 1);
    chk(ev, 2, "second dma");
    chk(hb, 6'h20, "second half");
    axr(IRQ_STAT_OFF, rd, rs);
    chk(rd[2:0], 3'h2, "half1 status");
    axr(STAT_OFF, rd, rs);
    chk(rd[5:0], 6'h0, "pointer wrap");
    for (int x = 0; x < 64; x++) begin
      axw(RAM_IDX_OFF, 32'(x), rs);
      for (int i = 0; i < 4; i++) begin
        axr(RAM_DATA0_OFF + 8'(4 * i), rd, rs);
        chk(rd, {mem[x][2*i+1], mem[x][2*i]}, "ram word");
      end
    end
    axw(CTRL_OFF, 32'h3, rs);
    EMU_SUSPEND <= 1'b1;
    bytes(8, 0);
    axr(STAT_OFF, rd, rs);
    chk(rd[5:0], 6'h0, "suspend pointer");
    EMU_SUSPEND <= 1'b0;
    axw(RAM_IDX_OFF, 32'h5, rs);
    // debug write reaches the ram port in the cycle in which the eighth byte fills entry 0, stalls, and lands the cycle after
    fork
      bytes(8, 1);
      begin
        repeat (5) @(posedge MCLK);
        axw(RAM_DATA0_OFF, 32'h5a3c_e1f0, rs);
      end
    join
    axr(RAM_DATA0_OFF, rd, rs);
    chk(rd, 32'h5a3c_e1f0, "debug write");
    axr(IRQ_STAT_OFF, rd, rs);
    chk(rd[2:0], 3'h6, "stall status");
    axr(STAT_OFF, rd, rs);
    chk(rd[5:0], 6'h1, "pointer after stall");
    axw(RAM_IDX_OFF, 32'h0, rs);
    for (int i = 0; i < 4; i++) begin
      axr(RAM_DATA0_OFF + 8'(4 * i), rd, rs);
      chk(rd, {mem[0][2*i+1], mem[0][2*i]}, "entry after stall");
    end
    end_sim();
  end
endmodule // tb_top
